//--- core/cfgprt_params.svh
// constants for the configuration protection options block
`ifndef CFGPRT_PARAMS_SVH
`define CFGPRT_PARAMS_SVH
// register byte offsets on the AXI4-Lite bus
`define CFGPRT_OFS_OPTIONS 8'h00
`define CFGPRT_OFS_GUARD_LO 8'h04
`define CFGPRT_OFS_GUARD_HI 8'h08
`define CFGPRT_OFS_TRG_LO 8'h0c
`define CFGPRT_OFS_TRG_HI 8'h10
`define CFGPRT_OFS_IDENT_HI 8'h14
`define CFGPRT_OFS_IDENT_LO 8'h18
`define CFGPRT_OFS_STATUS 8'h1c
`define CFGPRT_OFS_WR_GUARD 8'h20
// field positions in the options byte
`define CFGPRT_BIT_DEBUG 7
`define CFGPRT_BIT_BSZ_HI 5
`define CFGPRT_BIT_BSZ_LO 4
`define CFGPRT_BIT_SSP_EN 2
`define CFGPRT_BIT_STK_EN 0
// field positions in the guard bytes
`define CFGPRT_BIT_EE_GUARD 7
`define CFGPRT_BIT_BOOT_GUARD 6
`define CFGPRT_BIT_BLK0_GUARD 0
// implemented bit masks, unimplemented bits read zero
`define CFGPRT_MASK_OPTIONS 8'hb5
`define CFGPRT_MASK_GUARD_HI 8'hc0
`define CFGPRT_MASK_TRG_HI 8'h40
`define CFGPRT_MASK_WR_GUARD 8'h41
// boot area sizes in words
`define CFGPRT_WORDS_256 12'h100
`define CFGPRT_WORDS_512 12'h200
`define CFGPRT_WORDS_1K 12'h400
`define CFGPRT_WORDS_2K 12'h800
// default end of block 0, byte address
`define CFGPRT_BLK0_END 21'h001fff
// axi responses
`define CFGPRT_RESP_OKAY 2'b00
`define CFGPRT_RESP_SLVERR 2'b10
`endif

//--- core/cfgprt_pkg.sv
// types shared by the configuration protection options block
package cfgprt_pkg;
  typedef enum logic [1:0] {
    CFGPRT_RUN = 2'b00,
    CFGPRT_HV_PROG = 2'b01,
    CFGPRT_LV_PROG = 2'b10
  } cfgprt_mode_t;
  typedef enum logic [1:0] {
    CFGPRT_VAR_MID = 2'b00,
    CFGPRT_VAR_SMALL = 2'b01,
    CFGPRT_VAR_SINGLE = 2'b10
  } cfgprt_variant_t;
  typedef enum logic [1:0] {
    CFGPRT_REG_BOOT = 2'b00,
    CFGPRT_REG_BLK0 = 2'b01,
    CFGPRT_REG_OTHER = 2'b10
  } cfgprt_region_t;
endpackage

//--- core/cfgprt_top.sv
// configuration protection options: config image, mode control, guards, axi4-lite slave
`include "cfgprt_params.svh"

module cfgprt_top
  import cfgprt_pkg::*;
#(
  parameter cfgprt_variant_t VARIANT = CFGPRT_VAR_MID,
  parameter logic [5:0] BLOCK_MASK = 6'h0f,
  parameter logic [20:0] BLOCK0_END = `CFGPRT_BLK0_END,
  parameter logic [10:0] PART_ID = 11'h2a5, // arbitrary value
  parameter logic [4:0] STEP_CODE = 5'h03 // arbitrary value
)
(
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // nonvolatile storage contents presented at reset
  input wire logic [7:0] nv_options,
  input wire logic [7:0] nv_guard_lo,
  input wire logic [7:0] nv_guard_hi,
  input wire logic [7:0] nv_wr_guard,
  input wire logic [7:0] nv_trg_lo,
  input wire logic [7:0] nv_trg_hi,
  // programming entry pins
  input wire logic master_clear_prog_volt_pin,
  input wire logic shared_port_pin_i,
  output logic shared_port_pin_o,
  output logic shared_port_pin_oe,
  // port logic side of the shared pin
  input wire logic port_out,
  input wire logic port_oe,
  output logic port_in,
  // stack fault from the core
  input wire logic stack_fault,
  output logic stack_reset_req,
  // table read check
  input wire logic tbl_req,
  input wire logic [20:0] tbl_addr,
  input wire logic [20:0] tbl_exec_addr,
  output logic tbl_blocked,
  // effective protection state
  output logic [5:0] block_code_guard,
  output logic eeprom_code_guard,
  output logic boot_area_code_guard,
  output logic [11:0] boot_area_words,
  output logic [1:0] prog_mode
);

  // boot area size decode per variant
  function automatic logic [11:0] size_words(input logic [1:0] sel);
    logic [11:0] w;
    w = `CFGPRT_WORDS_256;
    unique case (VARIANT)
      CFGPRT_VAR_MID:
        w = sel[1] ? `CFGPRT_WORDS_1K : (sel[0] ? `CFGPRT_WORDS_512 : `CFGPRT_WORDS_256);
      CFGPRT_VAR_SMALL:
        w = (sel != 2'b00) ? `CFGPRT_WORDS_512 : `CFGPRT_WORDS_256;
      default:
        w = sel[0] ? `CFGPRT_WORDS_2K : `CFGPRT_WORDS_1K;
    endcase
    return w;
  endfunction

  // region of a byte address; block 0 follows the boot area directly
  function automatic cfgprt_region_t region_of(input logic [20:0] a, input logic [11:0] words);
    logic [20:0] boot_end;
    cfgprt_region_t r;
    boot_end = {8'h00, words, 1'b0};
    if (a < boot_end)
      r = CFGPRT_REG_BOOT;
    else if (a <= BLOCK0_END)
      r = CFGPRT_REG_BLK0;
    else
      r = CFGPRT_REG_OTHER;
    return r;
  endfunction

  // image registers (what the programmer sees) and effective copies
  logic [7:0] opt_q;
  logic [7:0] glo_q;
  logic [7:0] ghi_q;
  logic [7:0] wrg_q;
  logic [7:0] tlo_q;
  logic [7:0] thi_q;
  logic [7:0] eff_opt_q;
  logic [7:0] eff_glo_q;
  logic [7:0] eff_ghi_q;
  logic [7:0] eff_tlo_q;
  logic [7:0] eff_thi_q;
  cfgprt_mode_t mode_q;
  cfgprt_mode_t mode_d;

  // axi bookkeeping
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic wr_hit;
  logic [7:0] rd_val;
  logic rd_hit;
  logic in_prog;
  logic boot_locked;
  logic ssp_active;

  assign in_prog = (mode_q != CFGPRT_RUN);
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  // any of the six size-lock guards programmed to zero freezes the size field
  assign boot_locked = !ghi_q[`CFGPRT_BIT_BOOT_GUARD] || !glo_q[`CFGPRT_BIT_BLK0_GUARD] ||
                       !wrg_q[`CFGPRT_BIT_BOOT_GUARD] || !wrg_q[`CFGPRT_BIT_BLK0_GUARD] ||
                       !thi_q[`CFGPRT_BIT_BOOT_GUARD] || !tlo_q[`CFGPRT_BIT_BLK0_GUARD];
  // low-voltage path needs the enable set in both the loaded and current image
  assign ssp_active = eff_opt_q[`CFGPRT_BIT_SSP_EN] && opt_q[`CFGPRT_BIT_SSP_EN];

  // programming mode selection; high voltage always wins
  always_comb
  begin
    mode_d = mode_q;
    unique case (mode_q)
      CFGPRT_RUN:
      begin
        if (master_clear_prog_volt_pin)
          mode_d = CFGPRT_HV_PROG;
        else if (ssp_active && shared_port_pin_i)
          mode_d = CFGPRT_LV_PROG;
      end
      CFGPRT_HV_PROG:
      begin
        if (!master_clear_prog_volt_pin)
          mode_d = CFGPRT_RUN;
      end
      CFGPRT_LV_PROG:
      begin
        if (master_clear_prog_volt_pin)
          mode_d = CFGPRT_HV_PROG;
        else if (!shared_port_pin_i || !ssp_active)
          mode_d = CFGPRT_RUN;
      end
      default:
        mode_d = CFGPRT_RUN;
    endcase
  end

  // mode register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= CFGPRT_RUN;
    else
      mode_q <= mode_d;
  end

  // effective values: sampled from storage during reset, then frozen
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eff_opt_q <= nv_options & `CFGPRT_MASK_OPTIONS;
      eff_glo_q <= nv_guard_lo & {2'b00, BLOCK_MASK};
      eff_ghi_q <= nv_guard_hi & `CFGPRT_MASK_GUARD_HI;
      eff_tlo_q <= nv_trg_lo & {2'b00, BLOCK_MASK};
      eff_thi_q <= nv_trg_hi & `CFGPRT_MASK_TRG_HI;
    end
  end

  // image registers: loaded at reset, changed only by writes in programming mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      opt_q <= nv_options & `CFGPRT_MASK_OPTIONS;
      glo_q <= nv_guard_lo & {2'b00, BLOCK_MASK};
      ghi_q <= nv_guard_hi & `CFGPRT_MASK_GUARD_HI;
      wrg_q <= nv_wr_guard & `CFGPRT_MASK_WR_GUARD;
      tlo_q <= nv_trg_lo & {2'b00, BLOCK_MASK};
      thi_q <= nv_trg_hi & `CFGPRT_MASK_TRG_HI;
    end
    else if (do_write && wstrb_q[0] && in_prog)
    begin
      unique case (awaddr_q)
        `CFGPRT_OFS_OPTIONS:
        begin
          opt_q[`CFGPRT_BIT_DEBUG] <= wdata_q[`CFGPRT_BIT_DEBUG];
          opt_q[`CFGPRT_BIT_STK_EN] <= wdata_q[`CFGPRT_BIT_STK_EN];
          if (!boot_locked)
          begin
            opt_q[`CFGPRT_BIT_BSZ_HI] <= wdata_q[`CFGPRT_BIT_BSZ_HI];
            opt_q[`CFGPRT_BIT_BSZ_LO] <= wdata_q[`CFGPRT_BIT_BSZ_LO];
          end
          // clearing the low-voltage enable is only honoured under high voltage
          if (mode_q == CFGPRT_HV_PROG || wdata_q[`CFGPRT_BIT_SSP_EN])
            opt_q[`CFGPRT_BIT_SSP_EN] <= wdata_q[`CFGPRT_BIT_SSP_EN];
        end
        `CFGPRT_OFS_GUARD_LO:
          glo_q <= wdata_q[7:0] & {2'b00, BLOCK_MASK};
        `CFGPRT_OFS_GUARD_HI:
          ghi_q <= wdata_q[7:0] & `CFGPRT_MASK_GUARD_HI;
        `CFGPRT_OFS_WR_GUARD:
          wrg_q <= wdata_q[7:0] & `CFGPRT_MASK_WR_GUARD;
        `CFGPRT_OFS_TRG_LO:
          tlo_q <= wdata_q[7:0] & {2'b00, BLOCK_MASK};
        `CFGPRT_OFS_TRG_HI:
          thi_q <= wdata_q[7:0] & `CFGPRT_MASK_TRG_HI;
        default:
        begin
          // identification and status ignore writes
        end
      endcase
    end
  end

  // write address decode; id registers are refused
  always_comb
  begin
    unique case (awaddr_q)
      `CFGPRT_OFS_OPTIONS, `CFGPRT_OFS_GUARD_LO, `CFGPRT_OFS_GUARD_HI,
      `CFGPRT_OFS_WR_GUARD, `CFGPRT_OFS_TRG_LO, `CFGPRT_OFS_TRG_HI:
        wr_hit = 1'b1;
      default:
        wr_hit = 1'b0;
    endcase
  end

  // read mux, narrow registers in the low byte
  always_comb
  begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      `CFGPRT_OFS_OPTIONS: rd_val = opt_q;
      `CFGPRT_OFS_GUARD_LO: rd_val = glo_q;
      `CFGPRT_OFS_GUARD_HI: rd_val = ghi_q;
      `CFGPRT_OFS_WR_GUARD: rd_val = wrg_q;
      `CFGPRT_OFS_TRG_LO: rd_val = tlo_q;
      `CFGPRT_OFS_TRG_HI: rd_val = thi_q;
      `CFGPRT_OFS_IDENT_HI: rd_val = PART_ID[10:3];
      `CFGPRT_OFS_IDENT_LO: rd_val = {PART_ID[2:0], STEP_CODE};
      `CFGPRT_OFS_STATUS: rd_val = {4'h0, boot_locked, ssp_active, mode_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // write channels: take address and data in either order, answer once both held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CFGPRT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `CFGPRT_RESP_OKAY : `CFGPRT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one outstanding read, data registered on the address edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CFGPRT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_val};
      s_axi_rresp <= rd_hit ? `CFGPRT_RESP_OKAY : `CFGPRT_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // shared pin: entry input while enabled, otherwise plain gpio
  // keeping the driver off while enabled avoids fighting a programmer on the pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shared_port_pin_o <= 1'b0;
      shared_port_pin_oe <= 1'b0;
      port_in <= 1'b0;
    end
    else if (ssp_active || mode_q == CFGPRT_LV_PROG)
    begin
      shared_port_pin_o <= 1'b0;
      shared_port_pin_oe <= 1'b0;
      port_in <= 1'b0;
    end
    else
    begin
      shared_port_pin_o <= port_out;
      shared_port_pin_oe <= port_oe;
      port_in <= shared_port_pin_i;
    end
  end

  // stack fault reset request, follows the fault one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stack_reset_req <= 1'b0;
    else
      stack_reset_req <= stack_fault && eff_opt_q[`CFGPRT_BIT_STK_EN];
  end

  // table read guard: cross-region reads into guarded boot or block 0 are blocked
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tbl_blocked <= 1'b0;
    else if (!tbl_req)
      tbl_blocked <= 1'b0;
    else
    begin
      unique case (region_of(tbl_addr, boot_area_words))
        CFGPRT_REG_BOOT:
          tbl_blocked <= !eff_thi_q[`CFGPRT_BIT_BOOT_GUARD] &&
                         region_of(tbl_exec_addr, boot_area_words) != CFGPRT_REG_BOOT;
        CFGPRT_REG_BLK0:
          tbl_blocked <= !eff_tlo_q[`CFGPRT_BIT_BLK0_GUARD] &&
                         region_of(tbl_exec_addr, boot_area_words) != CFGPRT_REG_BLK0;
        default:
          tbl_blocked <= 1'b0;
      endcase
    end
  end

  // protection outputs, active high means protected
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      block_code_guard <= 6'h00;
      eeprom_code_guard <= 1'b0;
      boot_area_code_guard <= 1'b0;
      boot_area_words <= `CFGPRT_WORDS_256;
      prog_mode <= CFGPRT_RUN;
    end
    else
    begin
      block_code_guard <= ~eff_glo_q[5:0] & BLOCK_MASK;
      eeprom_code_guard <= !eff_ghi_q[`CFGPRT_BIT_EE_GUARD];
      boot_area_code_guard <= !eff_ghi_q[`CFGPRT_BIT_BOOT_GUARD];
      boot_area_words <= size_words(eff_opt_q[`CFGPRT_BIT_BSZ_HI:`CFGPRT_BIT_BSZ_LO]);
      prog_mode <= mode_q;
    end
  end

endmodule // cfgprt_top

//--- test/cfgprt_programmer.sv
// model of the external programmer driving the entry pins
module cfgprt_programmer (
  input wire logic aclk,
  input wire logic hv_req,
  input wire logic lv_req,
  input wire logic pin_oe,
  input wire logic pin_o,
  output logic mclr_pin,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lv_q = 1'h0;
  // pins move just after the edge, as a synchronous driver would
  always_ff @(posedge aclk)
  begin
    mclr_pin <= hv_req;
    lv_q <= lv_req;
  end
  // released entry line falls to its pull-down; the device wins when it drives
  assign pin_level = pin_oe ? pin_o : lv_q;
endmodule // cfgprt_programmer

//--- test/cfgprt_top_monitor.sv
// assertion checker for the configuration protection options block
module cfgprt_top_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic master_clear_prog_volt_pin,
  input wire logic shared_port_pin_oe,
  input wire logic port_in,
  input wire logic stack_fault,
  input wire logic stack_reset_req,
  input wire logic tbl_req,
  input wire logic [20:0] tbl_addr,
  input wire logic [20:0] tbl_exec_addr,
  input wire logic tbl_blocked,
  input wire logic [5:0] block_code_guard,
  input wire logic eeprom_code_guard,
  input wire logic boot_area_code_guard,
  input wire logic [11:0] boot_area_words,
  input wire logic [1:0] prog_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  // cycles since release; effective copies settle by the third edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= 2'h0;
    else if (cnt_q != 2'h3)
      cnt_q <= cnt_q + 2'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_stack_cause: assert property (stack_reset_req |-> $past(stack_fault))
    else $error("stack reset without a fault");
  a_lv_no_gpio: assert property (prog_mode == 2'h2 |-> !port_in && !shared_port_pin_oe)
    else $error("shared pin used as gpio in low-voltage mode");
  a_hv_always_enters: assert property (master_clear_prog_volt_pin [*4] |-> prog_mode == 2'h1)
    else $error("high voltage did not enter programming mode");
  a_tbl_cause: assert property (tbl_blocked |-> $past(tbl_req))
    else $error("table read blocked without request");
  a_tbl_same_region: assert property (tbl_req && tbl_addr == tbl_exec_addr |=> !tbl_blocked)
    else $error("read within own region blocked");
  a_words_legal: assert property (boot_area_words inside {12'h100, 12'h200, 12'h400})
    else $error("illegal boot area size");
  a_guard_hold: assert property (cnt_q == 2'h3 |->
    $stable({block_code_guard, eeprom_code_guard, boot_area_code_guard, boot_area_words}))
    else $error("effective configuration changed without reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
  a_wr_ready_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  a_rd_ready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready while data pending");
  c_hv: cover property (prog_mode == 2'h1);
  c_lv: cover property (prog_mode == 2'h2);
  c_tbl: cover property (tbl_blocked);
  c_stack: cover property (stack_reset_req);
endmodule // cfgprt_top_monitor

//--- test/test_config_protection_options.sv
// self-checking bench for the configuration protection options block
`include "cfgprt_params.svh"

module test_config_protection_options;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [10:0] PID = 11'h5c3; // arbitrary, differs from the default on purpose
  localparam logic [4:0] STP = 5'h1a; // arbitrary, differs from the default on purpose
  localparam logic [31:0] SZ [4] = '{32'h100, 32'h200, 32'h400, 32'h400};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [47:0] nvv = 48'hffffffffffff;
  logic hv_req = 1'h0, lv_req = 1'h0, port_out = 1'h0, port_oe = 1'h0, stack_fault = 1'h0, tbl_req = 1'h0;
  logic [20:0] tbl_addr = 21'h0, tbl_exec = 21'h0;
  logic awready, wready, bvalid, arready, rvalid, mclr, pin_i, pin_o, pin_oe, port_in, stk_req, tbl_blk, eeg, bag;
  logic [1:0] bresp, rresp, prog_mode;
  logic [31:0] rdata;
  logic [5:0] bcg;
  logic [11:0] words;
  int n_mismatch = 0;
  int checked = 0;

  always #20 aclk = ~aclk;

  cfgprt_top #(.BLOCK_MASK(6'h3f), .PART_ID(PID), .STEP_CODE(STP)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .nv_options(nvv[47:40]), .nv_guard_lo(nvv[39:32]), .nv_guard_hi(nvv[31:24]),
    .nv_wr_guard(nvv[23:16]), .nv_trg_lo(nvv[15:8]), .nv_trg_hi(nvv[7:0]), .master_clear_prog_volt_pin(mclr),
    .shared_port_pin_i(pin_i), .shared_port_pin_o(pin_o), .shared_port_pin_oe(pin_oe), .port_out(port_out),
    .port_oe(port_oe), .port_in(port_in), .stack_fault(stack_fault), .stack_reset_req(stk_req),
    .tbl_req(tbl_req), .tbl_addr(tbl_addr), .tbl_exec_addr(tbl_exec), .tbl_blocked(tbl_blk),
    .block_code_guard(bcg), .eeprom_code_guard(eeg), .boot_area_code_guard(bag), .boot_area_words(words),
    .prog_mode(prog_mode)
  );

  cfgprt_programmer u_prog (
    .aclk(aclk), .hv_req(hv_req), .lv_req(lv_req), .pin_oe(pin_oe), .pin_o(pin_o),
    .mclr_pin(mclr), .pin_level(pin_i)
  );

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("Error at %0t: no bus answer", $time);
    end_of_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // bus write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    if (i == 50) timeout();
    bready <= 1'h0;
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    if (i == 50) timeout();
    rready <= 1'h0;
    chk(32'(rresp), 32'(er));
    chk(rdata, {24'h0, ed});
  endtask

  // storage contents are presented from the start of reset and only sampled while it is held
  task automatic rst(input logic [47:0] v);
    @(posedge aclk);
    nvv <= v;
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    cyc(3);
  endtask

  task automatic stk(input logic exp);
    @(posedge aclk);
    stack_fault <= 1'h1;
    @(posedge aclk);
    stack_fault <= 1'h0;
    #1;
    chk(32'(stk_req), 32'(exp));
  endtask

  task automatic tbl(input logic [20:0] ex, input logic [20:0] ad, input logic exp);
    @(posedge aclk);
    tbl_req <= 1'h1;
    tbl_exec <= ex;
    tbl_addr <= ad;
    @(posedge aclk);
    tbl_req <= 1'h0;
    #1;
    chk(32'(tbl_blk), 32'(exp));
  endtask

  // main sequence
  initial
  begin
    int i;
    rst(48'hffffffffffff);
    rd(`CFGPRT_OFS_OPTIONS, 8'hb5, `CFGPRT_RESP_OKAY);
    chk(32'(words), 32'h400);
    chk(32'({bcg, eeg, bag}), 32'h0);
    rd(`CFGPRT_OFS_IDENT_HI, PID[10:3], `CFGPRT_RESP_OKAY);
    rd(`CFGPRT_OFS_IDENT_LO, {PID[2:0], STP}, `CFGPRT_RESP_OKAY);
    wr(`CFGPRT_OFS_IDENT_HI, 8'h00, `CFGPRT_RESP_SLVERR);
    rd(`CFGPRT_OFS_IDENT_HI, PID[10:3], `CFGPRT_RESP_OKAY);
    rd(8'h24, 8'h00, `CFGPRT_RESP_SLVERR);
    rd(`CFGPRT_OFS_STATUS, 8'h04, `CFGPRT_RESP_OKAY);
    wr(`CFGPRT_OFS_OPTIONS, 8'h00, `CFGPRT_RESP_OKAY);
    rd(`CFGPRT_OFS_OPTIONS, 8'hb5, `CFGPRT_RESP_OKAY);
    @(posedge aclk);
    port_oe <= 1'h1;
    port_out <= 1'h1;
    cyc(3);
    chk(32'({pin_oe, port_in}), 32'h0);
    stk(1'h1);
    @(posedge aclk);
    lv_req <= 1'h1;
    cyc(5);
    chk(32'({prog_mode, port_in}), 32'h4);
    // low-voltage mode may not clear the enable, other bits still land
    wr(`CFGPRT_OFS_OPTIONS, 8'h00, `CFGPRT_RESP_OKAY);
    rd(`CFGPRT_OFS_OPTIONS, 8'h04, `CFGPRT_RESP_OKAY);
    @(posedge aclk);
    lv_req <= 1'h0;
    hv_req <= 1'h1;
    cyc(5);
    chk(32'(prog_mode), 32'h1);
    wr(`CFGPRT_OFS_OPTIONS, 8'h00, `CFGPRT_RESP_OKAY);
    rd(`CFGPRT_OFS_OPTIONS, 8'h00, `CFGPRT_RESP_OKAY);
    wr(`CFGPRT_OFS_GUARD_LO, 8'h3e, `CFGPRT_RESP_OKAY);
    wr(`CFGPRT_OFS_OPTIONS, 8'h31, `CFGPRT_RESP_OKAY);
    rd(`CFGPRT_OFS_OPTIONS, 8'h01, `CFGPRT_RESP_OKAY);
    rd(`CFGPRT_OFS_STATUS, 8'h09, `CFGPRT_RESP_OKAY);
    chk(32'({bcg, words}), 32'h400);
    @(posedge aclk);
    hv_req <= 1'h0;
    lv_req <= 1'h1;
    cyc(6);
    chk(32'(prog_mode), 32'h0);
    lv_req <= 1'h0;
    $display("erased part test done");
    rst(48'h003e40ff3e00);
    chk(32'(bcg), 32'h1);
    chk(32'({eeg, bag}), 32'h2);
    chk(32'(words), 32'h100);
    chk(32'({pin_oe, pin_o, port_in}), 32'h7);
    stk(1'h0);
    tbl(21'h3000, 21'h0400, 1'h1);
    tbl(21'h3000, 21'h0100, 1'h1);
    tbl(21'h0100, 21'h0200, 1'h1);
    tbl(21'h0100, 21'h01fe, 1'h0);
    tbl(21'h0400, 21'h0400, 1'h0);
    $display("protected part test done");
    for (i = 0; i < 4; i++)
    begin
      rst({2'h3, i[1:0], 44'hfffffffffff});
      chk(32'(words), SZ[i]);
    end
    $display("size code test done");
    end_of_test();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    timeout();
  end
endmodule // test_config_protection_options

bind cfgprt_top cfgprt_top_monitor u_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arready, .s_axi_rvalid, .master_clear_prog_volt_pin, .shared_port_pin_oe, .port_in,
  .stack_fault, .stack_reset_req, .tbl_req, .tbl_addr, .tbl_exec_addr, .tbl_blocked, .block_code_guard,
  .eeprom_code_guard, .boot_area_code_guard, .boot_area_words, .prog_mode
);
